// [smcr_pkg.sv]
// Package with addresses, field layouts, reset values and codes of the synthesizer and modem configuration bank
package smcr_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [5:0] ADDR_SYNTH_OFFSET  = 6'h0c;
	localparam logic [5:0] ADDR_CARRIER_HIGH  = 6'h0d;
	localparam logic [5:0] ADDR_CARRIER_MID   = 6'h0e;
	localparam logic [5:0] ADDR_CARRIER_LOW   = 6'h0f;
	localparam logic [5:0] ADDR_FILTER_BW     = 6'h10;
	localparam logic [5:0] ADDR_RATE_MANT     = 6'h11;
	localparam logic [5:0] ADDR_MODEM_FORMAT  = 6'h12;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_SYNTH_OFFSET   = 8'h00;
	localparam logic [5:0] RST_CARRIER_HIGH   = 6'h1e;
	localparam logic [7:0] RST_CARRIER_MID    = 8'hc4;
	localparam logic [7:0] RST_CARRIER_LOW    = 8'hec;
	localparam logic [1:0] RST_BW_EXPONENT    = 2'h2;
	localparam logic [1:0] RST_BW_MANTISSA    = 2'h0;
	localparam logic [3:0] RST_RATE_EXPONENT  = 4'hc;
	localparam logic [7:0] RST_RATE_MANTISSA  = 8'h22;
	localparam logic       RST_DC_BLOCK_DIS   = 1'b0;
	localparam logic [2:0] RST_MODULATION     = 3'h0;

	// ==========================================================
	// Field positions
	localparam int CARRIER_HIGH_W  = 6;     // Bits 7:6 of the high byte are read-only zero
	localparam int BW_EXP_LSB      = 6;
	localparam int BW_MANT_LSB     = 4;
	localparam int RATE_EXP_LSB    = 0;
	localparam int DC_BLOCK_BIT    = 7;
	localparam int MOD_SEL_LSB     = 4;

	// ==========================================================
	// Arithmetic constants
	localparam int          OFFSET_SHIFT    = 2;      // 2^16 / 2^14 carrier steps per offset step
	localparam logic [2:0]  BW_BASE         = 3'h4;   // Added to the bandwidth mantissa
	localparam int          BW_SCALE_SHIFT  = 3;      // Multiply by 8
	localparam logic        RATE_HIDDEN_BIT = 1'b1;   // Ninth mantissa bit

	// ==========================================================
	// Modulation codes
	typedef enum logic [2:0] {
		SMCR_MOD_2FSK = 3'b000,
		SMCR_MOD_GFSK = 3'b001,
		SMCR_MOD_OOK  = 3'b011,
		SMCR_MOD_MSK  = 3'b111
	} smcr_mod_e;

endpackage : smcr_pkg

// [smcr_synth_sum.sv]
// Adder that folds the signed offset into the carrier word for the synthesizer
`timescale 1ns/100ps
module smcr_synth_sum (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// Operands
	input  wire logic [23:0] carrier_word,
	input  wire logic [7:0]  synth_offset,
	// Result
	output logic      [23:0] synth_word
);

	// ==========================================================
	// Offset scaling
	// One offset step is four carrier steps, so sign-extend and shift
	logic [23:0] offset_ext;
	assign offset_ext = 24'({{16{synth_offset[7]}}, synth_offset} << smcr_pkg::OFFSET_SHIFT);

	// Registered sum; wraps modulo 2^24 like the synthesizer word itself
	always_ff @(posedge core_clk) begin
		if (reset) begin
			synth_word <= 24'h000000;
		end else begin
			synth_word <= carrier_word + offset_ext;  // [RULE_01]
		end
	end

	// ==========================================================
	// Checks
	offset_sum_a: assert property (@(posedge core_clk) disable iff (reset) // [RULE_01]
		!$past(reset) |-> synth_word == 24'($past(carrier_word)
			+ 24'({{16{$past(synth_offset[7])}}, $past(synth_offset)} << smcr_pkg::OFFSET_SHIFT)))
		else $error("Synth word is not carrier plus scaled signed offset");

endmodule : smcr_synth_sum

// [smcr_config_regs.sv]
// Synthesizer and modem configuration register bank with derived control values
`timescale 1ns/100ps

// Functional notes
// RULE_01 - Signed 8-bit offset is added to the carrier word, step xtal/2^14.
// RULE_02 - Carrier word is high, middle and low bytes; step is xtal/2^16.
// RULE_03 - Carrier word bits 23:22 are read-only and always read zero.
// RULE_04 - Decimation ratio is 8 times (4 plus mantissa) times 2^exponent.
// RULE_05 - Symbol rate uses hidden ninth mantissa bit and a 4-bit exponent.
// RULE_06 - Format bit 7 set bypasses DC blocking; host uses it up to 250 kBaud.
// RULE_07 - Host rewrites the IF setting after disabling DC blocking.
// RULE_08 - Modulation select is format bits 6:4, reset to zero.
// RULE_09 - Codes 000 2-FSK, 001 GFSK, 011 OOK, 111 MSK; others unused.
// RULE_10 - Reset loads defaults; fields hold the last write until next write.
module smcr_config_regs (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// Register access
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	input  wire logic [5:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	// Synthesizer controls
	output logic      [23:0] carrier_word,
	output logic      [7:0]  synth_offset,
	output logic      [23:0] synth_word,
	// Channel filter controls
	output logic      [1:0]  bw_exponent,
	output logic      [1:0]  bw_mantissa,
	output logic      [8:0]  decim_ratio,
	// Symbol rate controls
	output logic      [3:0]  rate_exponent,
	output logic      [7:0]  rate_mantissa,
	output logic      [23:0] rate_increment,
	// Demodulator controls
	output logic             dc_block_disable,
	output logic      [2:0]  modulation_select,
	output logic             mod_is_2fsk,
	output logic             mod_is_gfsk,
	output logic             mod_is_ook,
	output logic             mod_is_msk,
	output logic             mod_unused
);

	// ==========================================================
	// Storage
	logic [7:0] synth_offset_r;
	logic [5:0] carrier_high_r;
	logic [7:0] carrier_mid_r;
	logic [7:0] carrier_low_r;
	logic [1:0] bw_exponent_r;
	logic [1:0] bw_mantissa_r;
	logic [3:0] rate_exponent_r;
	logic [7:0] rate_mantissa_r;
	logic       dc_block_disable_r;
	logic [2:0] modulation_r;
	logic [7:0] rdata_nxt;

	// Write strobe for one address
	function automatic logic hit(input logic en, input logic [5:0] a, input logic [5:0] target);
		hit = en && (a == target);
	endfunction : hit

	// Modulation decode into the one-hot flags
	function automatic logic [4:0] mod_decode(input logic [2:0] code);
		case (code)
			smcr_pkg::SMCR_MOD_2FSK: mod_decode = 5'h01;
			smcr_pkg::SMCR_MOD_GFSK: mod_decode = 5'h02;
			smcr_pkg::SMCR_MOD_OOK:  mod_decode = 5'h04;
			smcr_pkg::SMCR_MOD_MSK:  mod_decode = 5'h08;
			default:                 mod_decode = 5'h10;
		endcase
	endfunction : mod_decode

	// ==========================================================
	// Synthesizer registers
	// Only the six writable bits of the high byte are stored at all
	always_ff @(posedge core_clk) begin
		if (reset) begin
			synth_offset_r <= smcr_pkg::RST_SYNTH_OFFSET;  // [RULE_10]
			carrier_high_r <= smcr_pkg::RST_CARRIER_HIGH;
			carrier_mid_r  <= smcr_pkg::RST_CARRIER_MID;
			carrier_low_r  <= smcr_pkg::RST_CARRIER_LOW;
		end else begin
			if (hit(reg_wr_en, reg_addr, smcr_pkg::ADDR_SYNTH_OFFSET)) begin
				synth_offset_r <= reg_wdata;
			end
			if (hit(reg_wr_en, reg_addr, smcr_pkg::ADDR_CARRIER_HIGH)) begin
				carrier_high_r <= reg_wdata[smcr_pkg::CARRIER_HIGH_W-1:0];  // [RULE_03]
			end
			if (hit(reg_wr_en, reg_addr, smcr_pkg::ADDR_CARRIER_MID)) begin
				carrier_mid_r <= reg_wdata;
			end
			if (hit(reg_wr_en, reg_addr, smcr_pkg::ADDR_CARRIER_LOW)) begin
				carrier_low_r <= reg_wdata;
			end
		end
	end

	// ==========================================================
	// Modem registers
	always_ff @(posedge core_clk) begin
		if (reset) begin
			bw_exponent_r      <= smcr_pkg::RST_BW_EXPONENT;  // [RULE_10]
			bw_mantissa_r      <= smcr_pkg::RST_BW_MANTISSA;
			rate_exponent_r    <= smcr_pkg::RST_RATE_EXPONENT;
			rate_mantissa_r    <= smcr_pkg::RST_RATE_MANTISSA;
			dc_block_disable_r <= smcr_pkg::RST_DC_BLOCK_DIS;
			modulation_r       <= smcr_pkg::RST_MODULATION;  // [RULE_08]
		end else begin
			if (hit(reg_wr_en, reg_addr, smcr_pkg::ADDR_FILTER_BW)) begin
				bw_exponent_r   <= reg_wdata[smcr_pkg::BW_EXP_LSB +: 2];
				bw_mantissa_r   <= reg_wdata[smcr_pkg::BW_MANT_LSB +: 2];
				rate_exponent_r <= reg_wdata[smcr_pkg::RATE_EXP_LSB +: 4];
			end
			if (hit(reg_wr_en, reg_addr, smcr_pkg::ADDR_RATE_MANT)) begin
				rate_mantissa_r <= reg_wdata;
			end
			if (hit(reg_wr_en, reg_addr, smcr_pkg::ADDR_MODEM_FORMAT)) begin
				dc_block_disable_r <= reg_wdata[smcr_pkg::DC_BLOCK_BIT];  // [RULE_06]
				modulation_r       <= reg_wdata[smcr_pkg::MOD_SEL_LSB +: 3];  // [RULE_08]
			end
		end
	end

	// ==========================================================
	// Read path
	// Unmapped addresses and unstored bits read as zero
	always_comb begin
		case (reg_addr)
			smcr_pkg::ADDR_SYNTH_OFFSET: rdata_nxt = synth_offset_r;
			smcr_pkg::ADDR_CARRIER_HIGH: rdata_nxt = {2'b00, carrier_high_r};  // [RULE_03]
			smcr_pkg::ADDR_CARRIER_MID:  rdata_nxt = carrier_mid_r;
			smcr_pkg::ADDR_CARRIER_LOW:  rdata_nxt = carrier_low_r;
			smcr_pkg::ADDR_FILTER_BW:    rdata_nxt = {bw_exponent_r, bw_mantissa_r, rate_exponent_r};
			smcr_pkg::ADDR_RATE_MANT:    rdata_nxt = rate_mantissa_r;
			smcr_pkg::ADDR_MODEM_FORMAT: rdata_nxt = {dc_block_disable_r, modulation_r, 4'h0};
			default:                     rdata_nxt = 8'h00;
		endcase
	end

	// Read data registered, valid one cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (reset) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rdata <= rdata_nxt;
			end
		end
	end

	// ==========================================================
	// Derived controls
	assign carrier_word      = {2'b00, carrier_high_r, carrier_mid_r, carrier_low_r};  // [RULE_02]
	assign synth_offset      = synth_offset_r;
	assign bw_exponent       = bw_exponent_r;
	assign bw_mantissa       = bw_mantissa_r;
	assign rate_exponent     = rate_exponent_r;
	assign rate_mantissa     = rate_mantissa_r;
	assign dc_block_disable  = dc_block_disable_r;  // [RULE_06]
	assign modulation_select = modulation_r;

	// Ratio and rate increment are registered so their wide logic is off the output path
	always_ff @(posedge core_clk) begin
		if (reset) begin
			decim_ratio    <= 9'h000;
			rate_increment <= 24'h000000;
		end else begin
			decim_ratio <= 9'(({6'h00, smcr_pkg::BW_BASE} + {7'h00, bw_mantissa_r})
				<< (smcr_pkg::BW_SCALE_SHIFT + int'(bw_exponent_r)));  // [RULE_04]
			rate_increment <= 24'({15'h0000, smcr_pkg::RATE_HIDDEN_BIT, rate_mantissa_r}
				<< rate_exponent_r);  // [RULE_05]
		end
	end

	// Modulation flags; unused codes raise mod_unused and nothing else
	always_ff @(posedge core_clk) begin
		if (reset) begin
			{mod_unused, mod_is_msk, mod_is_ook, mod_is_gfsk, mod_is_2fsk} <= 5'h01;
		end else begin
			{mod_unused, mod_is_msk, mod_is_ook, mod_is_gfsk, mod_is_2fsk} <= mod_decode(modulation_r);  // [RULE_09]
		end
	end

	// Offset adder for the synthesizer [RULE_01]
	smcr_synth_sum u_synth_sum (
		.core_clk     (core_clk),
		.reset        (reset),
		.carrier_word (carrier_word),
		.synth_offset (synth_offset_r),
		.synth_word   (synth_word)
	);

	// ==========================================================
	// Checks
	sequence wr_to(logic [5:0] a);
		reg_wr_en && reg_addr == a;
	endsequence

	sequence rd_to(logic [5:0] a);
		reg_rd_en && reg_addr == a;
	endsequence

	carrier_low_a: assert property (@(posedge core_clk) disable iff (reset) // [RULE_02]
		wr_to(smcr_pkg::ADDR_CARRIER_LOW) |=> carrier_word[7:0] == $past(reg_wdata))
		else $error("Low carrier byte not taken from write");

	high_bits_zero_a: assert property (@(posedge core_clk) disable iff (reset) // [RULE_03]
		rd_to(smcr_pkg::ADDR_CARRIER_HIGH) |=> reg_rvalid && reg_rdata[7:6] == 2'b00
			&& carrier_word[23:22] == 2'b00)
		else $error("Carrier high bits not zero");

	decim_ratio_a: assert property (@(posedge core_clk) disable iff (reset) // [RULE_04]
		wr_to(smcr_pkg::ADDR_FILTER_BW) ##2 1 |-> decim_ratio ==
			9'((9'd4 + 9'($past(reg_wdata[5:4], 2))) << (3 + int'($past(reg_wdata[7:6], 2)))))
		else $error("Decimation ratio wrong after filter write");

	rate_word_a: assert property (@(posedge core_clk) disable iff (reset) // [RULE_05]
		wr_to(smcr_pkg::ADDR_RATE_MANT) ##2 1 |->
			rate_increment[rate_exponent +: 9] == {1'b1, $past(reg_wdata, 2)})
		else $error("Rate increment lacks hidden bit or mantissa");

	dc_block_a: assert property (@(posedge core_clk) disable iff (reset) // [RULE_06]
		wr_to(smcr_pkg::ADDR_MODEM_FORMAT) |=> dc_block_disable == $past(reg_wdata[7]))
		else $error("DC block bypass not following bit 7");

	mod_reset_a: assert property (@(posedge core_clk) // [RULE_08]
		$fell(reset) |-> modulation_select == 3'b000 && mod_is_2fsk)
		else $error("Modulation select not zero after reset");

	mod_decode_a: assert property (@(posedge core_clk) disable iff (reset) // [RULE_09]
		wr_to(smcr_pkg::ADDR_MODEM_FORMAT) ##2 1 |->
			mod_is_msk == ($past(reg_wdata[6:4], 2) == 3'b111)
			&& mod_unused == ($past(reg_wdata[6:4], 2) inside {3'b010, 3'b100, 3'b101, 3'b110}))
		else $error("Modulation flags disagree with code");

	reset_default_a: assert property (@(posedge core_clk) // [RULE_10]
		$fell(reset) |-> carrier_word == 24'h1ec4ec && rate_mantissa == 8'h22
			&& bw_exponent == 2'h2 && rate_exponent == 4'hc && synth_offset == 8'h00)
		else $error("Defaults not loaded by reset");

	hold_value_a: assert property (@(posedge core_clk) disable iff (reset) // [RULE_10]
		!reg_wr_en [*3] |=> $stable(carrier_word) && $stable(synth_offset) && $stable(modulation_select))
		else $error("Field changed without a write");

endmodule : smcr_config_regs

// [smcr_host_model.sv]
// Host model that drives the register strobes of the configuration bank
`timescale 1ns/100ps
module smcr_host_model #(
	parameter logic [5:0] IF_ADDR = 6'h0b     // Intermediate-frequency register, outside this bank
) (
	// Clock
	input  wire logic       core_clk,
	// Register access
	output logic            reg_wr_en,
	output logic            reg_rd_en,
	output logic      [5:0] reg_addr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	// ==========================================================
	// Idle bus at time zero
	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr  = 6'h00;
		reg_wdata = 8'h00;
	end

	// One-cycle write; released lines show the inverse so a stale value never passes
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr_en <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask : wr

	// One-cycle read; data and valid are taken one cycle after the strobe
	task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic v);
		@(posedge core_clk);
		reg_rd_en <= 1'b1;
		reg_addr  <= a;
		@(posedge core_clk);
		reg_rd_en <= 1'b0;
		reg_addr  <= ~a;
		#1;
		d = reg_rdata;
		v = reg_rvalid;
	endtask : rd

	// Bypass DC blocking only at rates up to 250 kBaud, MSK only above 26 kBaud
	task automatic dc_off(input logic [2:0] mode, input logic [7:0] if_val);
		wr(smcr_pkg::ADDR_MODEM_FORMAT, {1'b1, mode, 4'h0});
		wr(IF_ADDR, if_val);
	endtask : dc_off
endmodule : smcr_host_model

// [tb.sv]
// Self-checking bench for the synthesizer and modem configuration bank
`timescale 1ns/100ps
module tb;
	// ==========================================================
	// Signals
	logic        core_clk, reset, reg_wr_en, reg_rd_en, reg_rvalid;
	logic [5:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, synth_offset, rate_mantissa;
	logic [23:0] carrier_word, synth_word, rate_increment;
	logic [1:0]  bw_exponent, bw_mantissa;
	logic [8:0]  decim_ratio;
	logic [3:0]  rate_exponent;
	logic [2:0]  modulation_select;
	logic        dc_block_disable, mod_is_2fsk, mod_is_gfsk, mod_is_ook, mod_is_msk, mod_unused;
	int          err_count = 0;
	int          check_count = 0;
	logic [7:0]  rst_v [7] = '{8'h00, 8'h1e, 8'hc4, 8'hec, 8'h8c, 8'h22, 8'h00};
	logic [7:0]  offs [4] = '{8'hff, 8'h80, 8'h7f, 8'h01};

	// ==========================================================
	// Design and host
	smcr_config_regs u_smcr_config_regs (.core_clk, .reset, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_rvalid, .carrier_word, .synth_offset, .synth_word, .bw_exponent, .bw_mantissa,
		.decim_ratio, .rate_exponent, .rate_mantissa, .rate_increment, .dc_block_disable, .modulation_select,
		.mod_is_2fsk, .mod_is_gfsk, .mod_is_ook, .mod_is_msk, .mod_unused);
	smcr_host_model u_smcr_host_model (.core_clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_rvalid);

	// 40 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// ==========================================================
	// Checks and helpers
	task automatic chk_port(input string n, input logic [23:0] e, input logic [23:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk_port

	task automatic chk_rd(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       v;
		u_smcr_host_model.rd(a, d, v);
		chk_port("reg_rvalid", 24'h1, {23'h0, v});
		check_count++;
		if (d !== e) begin
			err_count++;
			$display("wrong value reg_rdata %h expected %h seen %h", a, e, d);
		end
	endtask : chk_rd

	// Derived outputs trail the fields by one cycle
	task automatic settle;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : settle

	task automatic chk_reset;
		for (int i = 0; i < 7; i++)
			chk_rd(6'h0c + 6'(i), rst_v[i]);
		chk_port("carrier_word", 24'h1ec4ec, carrier_word);
		chk_port("synth_word", 24'h1ec4ec, synth_word);
		chk_port("decim_ratio", 24'h80, {15'h0, decim_ratio});
		chk_port("rate_increment", 24'h122000, rate_increment);
		chk_port("fields", 24'h8c2200,
			{bw_exponent, bw_mantissa, rate_exponent, rate_mantissa, synth_offset});
		chk_port("modulation_select", 24'h0, {21'h0, modulation_select});
		chk_port("mod_flags", 24'h10, {19'h0, mod_is_2fsk, mod_is_gfsk, mod_is_ook, mod_is_msk, mod_unused});
	endtask : chk_reset

	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		give_verdict();
	end

	// ==========================================================
	// Tests
	initial begin
		logic [23:0] e;
		logic [4:0]  f;
		reset <= 1'b1;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		chk_reset();
		// IF rewrite lands outside the bank and must not alias into it
		u_smcr_host_model.dc_off(3'h7, 8'h0a);
		chk_rd(6'h0b, 8'h00);
		chk_rd(6'h13, 8'h00);
		chk_port("dc_block_disable", 24'h1, {23'h0, dc_block_disable});
		// Back to 2-FSK with DC blocking on, since the rate sweep below leaves both host limits
		u_smcr_host_model.wr(smcr_pkg::ADDR_MODEM_FORMAT, 8'h00);
		// Top two bits of the high byte never store
		u_smcr_host_model.wr(smcr_pkg::ADDR_CARRIER_HIGH, 8'hff);
		u_smcr_host_model.wr(smcr_pkg::ADDR_CARRIER_MID, 8'h45);
		u_smcr_host_model.wr(smcr_pkg::ADDR_CARRIER_LOW, 8'h67);
		chk_rd(smcr_pkg::ADDR_CARRIER_HIGH, 8'h3f);
		chk_port("carrier_word", 24'h3f4567, carrier_word);
		// Carrier of one so negative offsets wrap below zero
		u_smcr_host_model.wr(smcr_pkg::ADDR_CARRIER_HIGH, 8'h00);
		u_smcr_host_model.wr(smcr_pkg::ADDR_CARRIER_MID, 8'h00);
		u_smcr_host_model.wr(smcr_pkg::ADDR_CARRIER_LOW, 8'h01);
		foreach (offs[k]) begin
			u_smcr_host_model.wr(smcr_pkg::ADDR_SYNTH_OFFSET, offs[k]);
			settle();
			e = 24'h1 + {{14{offs[k][7]}}, offs[k], 2'b00};
			chk_port("synth_word", e, synth_word);
		end
		// Every bandwidth pair and every rate exponent
		u_smcr_host_model.wr(smcr_pkg::ADDR_RATE_MANT, 8'hff);
		for (int i = 0; i < 16; i++) begin
			u_smcr_host_model.wr(smcr_pkg::ADDR_FILTER_BW, {i[3:2], i[1:0], i[3:0]});
			settle();
			e = (24'd32 + 24'd8 * i[1:0]) << i[3:2];
			chk_port("decim_ratio", e, {15'h0, decim_ratio});
			chk_port("rate_increment", 24'h1ff << i, rate_increment);
			e = {8'h0, i[3:2], i[1:0], i[3:0], 8'hff};
			chk_port("fields", e, {8'h0, bw_exponent, bw_mantissa, rate_exponent, rate_mantissa});
			chk_rd(smcr_pkg::ADDR_FILTER_BW, {i[3:2], i[1:0], i[3:0]});
		end
		// Reset exponent with full mantissa keeps the rate between the MSK floor and the bypass ceiling
		u_smcr_host_model.wr(smcr_pkg::ADDR_FILTER_BW, 8'h8c);
		settle();
		chk_port("rate_increment", 24'h1ff000, rate_increment);
		// Every modulation code, low nibble refused; each bypass is followed by the IF rewrite
		for (int c = 0; c < 8; c++) begin
			u_smcr_host_model.wr(smcr_pkg::ADDR_MODEM_FORMAT, {c[0], c[2:0], 4'hf});
			if (c[0])
				u_smcr_host_model.wr(6'h0b, 8'h0a);
			settle();
			f = (c == 0) ? 5'h10 : (c == 1) ? 5'h08 : (c == 3) ? 5'h04 : (c == 7) ? 5'h02 : 5'h01;
			chk_rd(smcr_pkg::ADDR_MODEM_FORMAT, {c[0], c[2:0], 4'h0});
			chk_port("modulation_select", {21'h0, c[2:0]}, {21'h0, modulation_select});
			chk_port("dc_block_disable", {23'h0, c[0]}, {23'h0, dc_block_disable});
			chk_port("mod_flags", {19'h0, f}, {19'h0, mod_is_2fsk, mod_is_gfsk, mod_is_ook, mod_is_msk, mod_unused});
		end
		// Second reset in mid-run restores every default
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		chk_reset();
		give_verdict();
	end
endmodule : tb
